/* File: dsr_pkg.sv */
package dsr_pkg;
	// debug control block word addresses
	localparam logic [31:0] ADDR_HALT_CTRL   = 32'hE000EDF0;
	localparam logic [31:0] ADDR_CORE_SEL    = 32'hE000EDF4;
	localparam logic [31:0] ADDR_CORE_DATA   = 32'hE000EDF8;
	localparam logic [31:0] ADDR_EXC_MON     = 32'hE000EDFC;
	localparam logic [31:0] ADDR_EXT_LO      = 32'hE000EE00;
	localparam logic [31:0] ADDR_EXT_HI      = 32'hE000EEFF;
	// system control block words, placed inside its space
	localparam logic [31:0] ADDR_SYS_HANDLER = 32'hE000ED24;
	localparam logic [31:0] ADDR_EVENT_CAUSE = 32'hE000ED30;

	// halting control fields
	localparam int          KEY_MSB          = 31;
	localparam int          KEY_LSB          = 16;
	localparam logic [15:0] WRITE_KEY        = 16'hA05F;
	localparam int          HC_DEBUGEN       = 0;
	localparam int          HC_HALT          = 1;
	localparam int          HC_STEP          = 2;
	localparam int          HC_MASKINTS      = 3;
	localparam logic [15:0] HC_CTRL_MASK     = 16'h000F;
	localparam int          HC_S_HALT        = 17;

	// system handler state field
	localparam int          SH_SVC_PEND      = 15;

	// event cause fields
	localparam int          EC_HALTED        = 0;
	localparam int          EC_BREAKPOINT    = 1;
	localparam int          EC_WATCH         = 2;
	localparam int          EC_VECTOR        = 3;
	localparam int          EC_EXTERNAL      = 4;
	localparam int          EC_WIDTH         = 5;

	// reset values
	localparam logic [31:0] RST_WORD         = 32'h0000_0000;
	localparam logic [4:0]  RST_CAUSE        = 5'h00;
endpackage : dsr_pkg

/* File: dsr_block.sv */
`timescale 1ns/1ps
// Functional notes
// R1: halting control at E000EDF0 read-write, core selector at E000EDF4 write-only.
// R2: core data at E000EDF8 and exception monitor control at E000EDFC, read-write.
// R3: E000EE00 to E000EEFF reserved: reads zero, writes ignored.
// R4: every debug control block register is one 32-bit word.
// R5: all registers reachable from the debug access port.
// R6: system handler bit 15 reads and writes supervisor call pending.
// R7: pending sets on exception occurrence, clears when exception becomes active.
// R8: event cause: write one clears bit, write zero leaves it.
// R9: halted flag read by a stepped instruction may be arbitrary.
// R10: power-on reset clears all event cause bits.
// R11: local reset leaves event cause register unchanged.
// R12: bit 4 sets on external halt request assertion.
// R13: bit 3 sets on vector catch event.
// R14: bit 2 sets on watch unit debug event.
// R15: bit 1 sets on breakpoint instruction or breakpoint unit match.
// R16: bit 0 sets on halt or step request event.
// R17: reserved bits of event cause and system handler registers.
// R18: completed single step sets halted flag and re-enters halt.
// R19: halting control low half written only with key A05F in top.
// R20: reserved bits read zero, writes to them ignored.
module dsr_block (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        local_reset_n,
	input  wire logic        dap_sel,
	input  wire logic        dap_wr,
	input  wire logic [31:0] dap_addr,
	input  wire logic [31:0] dap_wdata,
	output logic      [31:0] dap_rdata,
	output logic             dap_ack,
	input  wire logic        external_halt_request_in,
	input  wire logic        vector_catch_event,
	input  wire logic        watch_unit_event,
	input  wire logic        breakpoint_event,
	input  wire logic        step_done,
	input  wire logic        svc_occur,
	input  wire logic        svc_activate,
	input  wire logic        core_halted,
	output logic             halt_req_out,
	output logic             step_req_out,
	output logic             debug_en_out,
	output logic             mask_ints_out,
	output logic             core_sel_strobe,
	output logic      [31:0] core_sel_out,
	output logic      [31:0] core_data_out,
	output logic      [31:0] exc_mon_out,
	output logic             supervisor_call_pending
);
	logic [15:0]          hc_ctrl_ff;
	logic [31:0]          core_data_ff;
	logic [31:0]          exc_mon_ff;
	logic [31:0]          core_sel_ff;
	logic                 sel_stb_ff;
	logic                 svc_pend_ff;
	logic [4:0]           cause_ff;
	logic [4:0]           nxt_cause;
	logic [4:0]           cause_set;
	logic [4:0]           cause_clr;
	logic                 wr;
	logic                 halt_req_q;
	logic                 ext_q;

	assign wr = dap_sel & dap_wr;

	// halting control low half, guarded by key; local reset clears it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hc_ctrl_ff <= dsr_pkg::RST_WORD[15:0];
		end else if (!local_reset_n) begin
			hc_ctrl_ff <= dsr_pkg::RST_WORD[15:0];
		end else if (wr && dap_addr == dsr_pkg::ADDR_HALT_CTRL && // R1
			dap_wdata[dsr_pkg::KEY_MSB:dsr_pkg::KEY_LSB] == dsr_pkg::WRITE_KEY) begin // R19
			hc_ctrl_ff <= dap_wdata[15:0] & dsr_pkg::HC_CTRL_MASK; // R20
		end else if (step_done) begin
			hc_ctrl_ff[dsr_pkg::HC_HALT] <= 1'b1; // R18
		end
	end

	// plain read-write and write-only words
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_data_ff <= dsr_pkg::RST_WORD;
			exc_mon_ff   <= dsr_pkg::RST_WORD;
			core_sel_ff  <= dsr_pkg::RST_WORD;
			sel_stb_ff   <= 1'b0;
		end else begin
			sel_stb_ff <= 1'b0;
			if (wr && dap_addr == dsr_pkg::ADDR_CORE_SEL) begin // R1
				core_sel_ff <= dap_wdata;
				sel_stb_ff  <= 1'b1;
			end
			if (wr && dap_addr == dsr_pkg::ADDR_CORE_DATA) begin // R2
				core_data_ff <= dap_wdata; // R4
			end
			if (wr && dap_addr == dsr_pkg::ADDR_EXC_MON) begin // R2
				exc_mon_ff <= dap_wdata;
			end
		end
	end

	// supervisor call pending: debugger write first, then occurrence, then activation
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			svc_pend_ff <= 1'b0;
		end else if (wr && dap_addr == dsr_pkg::ADDR_SYS_HANDLER) begin
			svc_pend_ff <= dap_wdata[dsr_pkg::SH_SVC_PEND]; // R6
		end else if (svc_occur) begin
			svc_pend_ff <= 1'b1; // R7
		end else if (svc_activate) begin
			svc_pend_ff <= 1'b0; // R7
		end
	end

	// edge detect so a held request records once, not every cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_q      <= 1'b0;
			halt_req_q <= 1'b0;
		end else begin
			ext_q      <= external_halt_request_in;
			halt_req_q <= hc_ctrl_ff[dsr_pkg::HC_HALT] & hc_ctrl_ff[dsr_pkg::HC_DEBUGEN];
		end
	end

	// event cause sources and write-one-clear; set wins over clear
	always_comb begin
		cause_set = '0;
		cause_set[dsr_pkg::EC_EXTERNAL] = external_halt_request_in & ~ext_q; // R12
		cause_set[dsr_pkg::EC_VECTOR]     = vector_catch_event; // R13
		cause_set[dsr_pkg::EC_WATCH]      = watch_unit_event; // R14
		cause_set[dsr_pkg::EC_BREAKPOINT] = breakpoint_event; // R15
		cause_set[dsr_pkg::EC_HALTED]   = (hc_ctrl_ff[dsr_pkg::HC_HALT]
			& hc_ctrl_ff[dsr_pkg::HC_DEBUGEN] & ~halt_req_q) | step_done; // R16 R18
		cause_clr = '0;
		if (wr && dap_addr == dsr_pkg::ADDR_EVENT_CAUSE) begin
			cause_clr = dap_wdata[dsr_pkg::EC_WIDTH-1:0]; // R8 R17
		end
		nxt_cause = (cause_ff & ~cause_clr) | cause_set;
	end

	// only power-on reset touches the cause bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cause_ff <= dsr_pkg::RST_CAUSE; // R10
		end else begin
			cause_ff <= nxt_cause; // R11
		end
	end

	// read port; a stepped read of halted is not special-cased
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dap_rdata <= dsr_pkg::RST_WORD;
			dap_ack   <= 1'b0;
		end else begin
			dap_ack   <= dap_sel; // R5
			dap_rdata <= dsr_pkg::RST_WORD; // R3 R20
			if (dap_sel && !dap_wr) begin
				case (dap_addr)
					dsr_pkg::ADDR_HALT_CTRL: begin
						dap_rdata[15:0] <= hc_ctrl_ff;
						dap_rdata[dsr_pkg::HC_S_HALT] <= core_halted;
					end
					dsr_pkg::ADDR_CORE_DATA: begin
						dap_rdata <= core_data_ff;
					end
					dsr_pkg::ADDR_EXC_MON: begin
						dap_rdata <= exc_mon_ff;
					end
					dsr_pkg::ADDR_SYS_HANDLER: begin
						dap_rdata[dsr_pkg::SH_SVC_PEND] <= svc_pend_ff; // R6 R17
					end
					dsr_pkg::ADDR_EVENT_CAUSE: begin
						dap_rdata[dsr_pkg::EC_WIDTH-1:0] <= cause_ff; // R9
					end
					default: begin
						dap_rdata <= dsr_pkg::RST_WORD;
					end
				endcase
			end
		end
	end

	// control outputs straight from flip-flops
	always_comb begin
		halt_req_out            = hc_ctrl_ff[dsr_pkg::HC_HALT];
		step_req_out            = hc_ctrl_ff[dsr_pkg::HC_STEP];
		debug_en_out            = hc_ctrl_ff[dsr_pkg::HC_DEBUGEN];
		mask_ints_out           = hc_ctrl_ff[dsr_pkg::HC_MASKINTS];
		core_sel_strobe         = sel_stb_ff;
		core_sel_out            = core_sel_ff;
		core_data_out           = core_data_ff;
		exc_mon_out             = exc_mon_ff;
		supervisor_call_pending = svc_pend_ff;
	end

	AST_KEYLESS_IGNORED: assert property (@(posedge clk) disable iff (!reset_n) // R19
		(wr && dap_addr == dsr_pkg::ADDR_HALT_CTRL && local_reset_n && !step_done
		&& dap_wdata[31:16] != dsr_pkg::WRITE_KEY) |=> $stable(hc_ctrl_ff))
		else $error("keyless write changed halting control");
	AST_W1C: assert property (@(posedge clk) disable iff (!reset_n) // R8
		(wr && dap_addr == dsr_pkg::ADDR_EVENT_CAUSE && dap_wdata[1] && !breakpoint_event)
		|=> !cause_ff[dsr_pkg::EC_BREAKPOINT])
		else $error("write one did not clear cause bit");
	AST_W0_KEEP: assert property (@(posedge clk) disable iff (!reset_n) // R8
		(cause_ff[dsr_pkg::EC_WATCH] && !(wr && dap_addr == dsr_pkg::ADDR_EVENT_CAUSE
		&& dap_wdata[2])) |=> cause_ff[dsr_pkg::EC_WATCH])
		else $error("cause bit lost without clear");
	AST_EXT_SET: assert property (@(posedge clk) disable iff (!reset_n) // R12
		$rose(external_halt_request_in) |=> cause_ff[dsr_pkg::EC_EXTERNAL])
		else $error("external request not recorded");
	AST_VC_SET: assert property (@(posedge clk) disable iff (!reset_n) // R13
		vector_catch_event |=> cause_ff[dsr_pkg::EC_VECTOR])
		else $error("vector catch not recorded");
	AST_BK_SET: assert property (@(posedge clk) disable iff (!reset_n) // R15
		breakpoint_event |=> cause_ff[dsr_pkg::EC_BREAKPOINT])
		else $error("breakpoint not recorded");
	AST_STEP_DONE: assert property (@(posedge clk) disable iff (!reset_n) // R18
		(step_done && local_reset_n && !(wr && dap_addr == dsr_pkg::ADDR_HALT_CTRL))
		|=> (cause_ff[0] && halt_req_out))
		else $error("step completion did not halt");
	AST_LOCAL_KEEP: assert property (@(posedge clk) disable iff (!reset_n) // R11
		(!local_reset_n && !(dap_sel && dap_wr)) |=> (cause_ff & $past(cause_ff)) == $past(cause_ff))
		else $error("local reset disturbed cause bits");
	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // R20
		(dap_sel && !dap_wr && dap_addr == dsr_pkg::ADDR_EVENT_CAUSE) |=> dap_rdata[31:5] == 27'h0)
		else $error("reserved bits read nonzero");
	AST_SVC_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // R6
		(wr && dap_addr == dsr_pkg::ADDR_SYS_HANDLER) |=> svc_pend_ff == $past(dap_wdata[15]))
		else $error("pending write not applied");

	// every access answered exactly one cycle later
	AST_ACK_FOLLOWS: assert property (@(posedge clk) disable iff (!reset_n) // R5
		dap_sel |=> dap_ack)
		else $error("access not acknowledged");

	// no answer without a request, so a debugger never sees a ghost word
	AST_ACK_ONLY: assert property (@(posedge clk) disable iff (!reset_n) // R5
		!dap_sel |=> !dap_ack)
		else $error("acknowledge without access");

	// selector is write-only, a read comes back empty
	AST_SEL_READS_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // R1
		(dap_sel && !dap_wr && dap_addr == dsr_pkg::ADDR_CORE_SEL) |=> dap_rdata == 32'h0000_0000)
		else $error("selector read nonzero");

	// extension range has no function yet
	AST_EXT_RANGE_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // R3
		(dap_sel && !dap_wr && dap_addr >= dsr_pkg::ADDR_EXT_LO && dap_addr <= dsr_pkg::ADDR_EXT_HI)
		|=> dap_rdata == 32'h0000_0000)
		else $error("reserved range read nonzero");

	// selector write lands and strobes the core once
	AST_SEL_STROBE: assert property (@(posedge clk) disable iff (!reset_n) // R1
		(wr && dap_addr == dsr_pkg::ADDR_CORE_SEL) |=> (core_sel_strobe && core_sel_out == $past(dap_wdata)))
		else $error("selector write not applied");

	// whole-word data register write
	AST_CORE_DATA_WR: assert property (@(posedge clk) disable iff (!reset_n) // R2
		(wr && dap_addr == dsr_pkg::ADDR_CORE_DATA) |=> core_data_out == $past(dap_wdata))
		else $error("core data write not applied");

	// whole-word monitor control write
	AST_EXC_MON_WR: assert property (@(posedge clk) disable iff (!reset_n) // R2
		(wr && dap_addr == dsr_pkg::ADDR_EXC_MON) |=> exc_mon_out == $past(dap_wdata))
		else $error("monitor control write not applied");

	// watch unit event recorded next cycle
	AST_WATCH_SET: assert property (@(posedge clk) disable iff (!reset_n) // R14
		watch_unit_event |=> cause_ff[dsr_pkg::EC_WATCH])
		else $error("watch event not recorded");

	// keyed control write, then its effects
	sequence s_keyed_ctrl_write;
		wr && dap_addr == dsr_pkg::ADDR_HALT_CTRL && local_reset_n
		&& dap_wdata[31:16] == dsr_pkg::WRITE_KEY;
	endsequence
	sequence s_halt_from_idle;
		dap_wdata[1:0] == 2'b11 && !(halt_req_out && debug_en_out);
	endsequence

	// a keyed write takes the four control bits as written
	AST_KEYED_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // R19
		s_keyed_ctrl_write |=> {mask_ints_out, step_req_out, halt_req_out, debug_en_out}
		== $past(dap_wdata[3:0]))
		else $error("keyed write not applied");

	// halt request from idle shows as a cause two cycles on
	AST_HALT_CAUSE: assert property (@(posedge clk) disable iff (!reset_n) // R16
		s_keyed_ctrl_write ##0 s_halt_from_idle |-> ##2 cause_ff[dsr_pkg::EC_HALTED])
		else $error("halt request not recorded");

	// occurrence pends the call unless a debugger write overrides it
	AST_SVC_OCCUR: assert property (@(posedge clk) disable iff (!reset_n) // R7
		(svc_occur && !(wr && dap_addr == dsr_pkg::ADDR_SYS_HANDLER)) |=> supervisor_call_pending)
		else $error("call occurrence not pended");

	// activation clears pending when nothing else competes
	AST_SVC_ACTIVE: assert property (@(posedge clk) disable iff (!reset_n) // R7
		(svc_activate && !svc_occur && !(wr && dap_addr == dsr_pkg::ADDR_SYS_HANDLER))
		|=> !supervisor_call_pending)
		else $error("call activation did not clear pending");

	// handler word shows only the pending bit
	AST_HANDLER_RSVD: assert property (@(posedge clk) disable iff (!reset_n) // R17
		(dap_sel && !dap_wr && dap_addr == dsr_pkg::ADDR_SYS_HANDLER)
		|=> (dap_rdata[31:16] == 16'h0000 && dap_rdata[14:0] == 15'h0000))
		else $error("handler reserved bits nonzero");

	// cause read returns the recorded bits as they stood
	AST_CAUSE_READ: assert property (@(posedge clk) disable iff (!reset_n) // R9
		(dap_sel && !dap_wr && dap_addr == dsr_pkg::ADDR_EVENT_CAUSE)
		|=> dap_rdata[4:0] == $past(cause_ff))
		else $error("cause read mismatch");
endmodule : dsr_block

/* File: dsr_dbg_model.sv */
`timescale 1ns/1ps
module dsr_dbg_model (
	input  wire logic        clk,
	output logic             dap_sel,
	output logic             dap_wr,
	output logic      [31:0] dap_addr,
	output logic      [31:0] dap_wdata,
	input  wire logic [31:0] dap_rdata,
	input  wire logic        dap_ack
);
	// idle bus before the first access
	initial begin
		dap_sel = 1'b0;
		dap_wr = 1'b0;
		dap_addr = 32'h0;
		dap_wdata = 32'h0;
	end
	// one whole word, answer sampled mid-cycle after the taking edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic k);
		@(negedge clk);
		dap_sel = 1'b1;
		dap_wr = w;
		dap_addr = a;
		dap_wdata = d;
		@(negedge clk);
		r = dap_rdata;
		k = dap_ack;
		// released lines show inverted data so a stale value never looks valid
		dap_sel = 1'b0;
		dap_wr = ~w;
		dap_addr = ~a;
		dap_wdata = ~d;
	endtask : xfer
	// halting control writes always carry the key
	task automatic hc_wr(input logic [15:0] lo);
		logic [31:0] r;
		logic        k;
		xfer(1'b1, dsr_pkg::ADDR_HALT_CTRL, {dsr_pkg::WRITE_KEY, lo}, r, k);
	endtask : hc_wr
endmodule : dsr_dbg_model

/* File: dsr_block_tb.sv */
`timescale 1ns/1ps
module dsr_block_tb;
	localparam logic [31:0] A_EC = dsr_pkg::ADDR_EVENT_CAUSE;
	localparam logic [31:0] A_SH = dsr_pkg::ADDR_SYS_HANDLER;
	logic        clk, reset_n, lrst_n, sel, wr, ack, ak;
	logic [31:0] addr, wdata, rdata, rd, sel_out, data_out, mon_out;
	logic        ext, vc, wat, bk, sdone, occ, act, chalt, hreq, sreq, den, mint, strb, pend;
	int          err_total = 0;
	int          check_count = 0;

	dsr_block dut (.clk(clk), .reset_n(reset_n), .local_reset_n(lrst_n), .dap_sel(sel),
		.dap_wr(wr), .dap_addr(addr), .dap_wdata(wdata), .dap_rdata(rdata), .dap_ack(ack),
		.external_halt_request_in(ext), .vector_catch_event(vc), .watch_unit_event(wat),
		.breakpoint_event(bk), .step_done(sdone), .svc_occur(occ), .svc_activate(act),
		.core_halted(chalt), .halt_req_out(hreq), .step_req_out(sreq), .debug_en_out(den),
		.mask_ints_out(mint), .core_sel_strobe(strb), .core_sel_out(sel_out),
		.core_data_out(data_out), .exc_mon_out(mon_out), .supervisor_call_pending(pend));
	dsr_dbg_model dbg (.clk(clk), .dap_sel(sel), .dap_wr(wr), .dap_addr(addr),
		.dap_wdata(wdata), .dap_rdata(rdata), .dap_ack(ack));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// a read is judged on both its acknowledge and its data
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		dbg.xfer(1'b0, a, 32'h0, rd, ak);
		chk(32'(ak), 32'h1);
		chk(rd, exp);
	endtask : rdc
	// extra edge lets registered outputs settle before they are looked at
	task automatic wrc(input logic [31:0] a, input logic [31:0] d);
		dbg.xfer(1'b1, a, d, rd, ak);
		@(negedge clk);
	endtask : wrc
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	task automatic t_regs();
		rdc(A_EC, 32'h0);
		rdc(dsr_pkg::ADDR_EXT_LO, 32'h0);
		wrc(dsr_pkg::ADDR_EXT_HI, 32'hFFFF_FFFF);
		rdc(dsr_pkg::ADDR_EXT_HI, 32'h0);
		wrc(dsr_pkg::ADDR_CORE_DATA, 32'hA5A5_5A5A);
		rdc(dsr_pkg::ADDR_CORE_DATA, 32'hA5A5_5A5A);
		chk(data_out, 32'hA5A5_5A5A);
		wrc(dsr_pkg::ADDR_EXC_MON, 32'h0102_0304);
		rdc(dsr_pkg::ADDR_EXC_MON, 32'h0102_0304);
		chk(mon_out, 32'h0102_0304);
		dbg.xfer(1'b1, dsr_pkg::ADDR_CORE_SEL, 32'h0000_0011, rd, ak);
		chk(32'(strb), 32'h1);
		@(negedge clk);
		chk(32'(strb), 32'h0);
		chk(sel_out, 32'h0000_0011);
		rdc(dsr_pkg::ADDR_CORE_SEL, 32'h0);
		wrc(dsr_pkg::ADDR_HALT_CTRL, 32'h0000_0001);
		chk(32'(den), 32'h0);
		chalt = 1'b1;
		dbg.hc_wr(16'h0001);
		rdc(dsr_pkg::ADDR_HALT_CTRL, 32'h0002_0001);
		dbg.hc_wr(16'h000C);
		chk(32'(sreq), 32'h1);
		chk(32'(mint), 32'h1);
		$display("test registers done");
	endtask : t_regs
	task automatic t_events();
		pulse(bk);
		pulse(wat);
		pulse(vc);
		@(negedge clk) ext = 1'b1;
		rdc(A_EC, 32'h0000_001E);
		wrc(A_EC, 32'h0000_0002);
		rdc(A_EC, 32'h0000_001C);
		wrc(A_EC, 32'hFFFF_FFE0);
		rdc(A_EC, 32'h0000_001C);
		ext = 1'b0;
		wrc(A_EC, 32'h0000_001F);
		dbg.hc_wr(16'h0000);
		pulse(sdone);
		rdc(A_EC, 32'h0000_0001);
		wrc(A_EC, 32'h0000_0001);
		dbg.hc_wr(16'h0000);
		dbg.hc_wr(16'h0003);
		@(negedge clk);
		rdc(A_EC, 32'h0000_0001);
		chk(32'(hreq), 32'h1);
		$display("test events done");
	endtask : t_events
	task automatic t_svc();
		pulse(occ);
		rdc(A_SH, 32'h0000_8000);
		pulse(act);
		rdc(A_SH, 32'h0);
		wrc(A_SH, 32'hFFFF_FFFF);
		rdc(A_SH, 32'h0000_8000);
		chk(32'(pend), 32'h1);
		pulse(bk);
		@(negedge clk) lrst_n = 1'b0;
		@(negedge clk) lrst_n = 1'b1;
		rdc(A_EC, 32'h0000_0003);
		@(negedge clk) reset_n = 1'b0;
		@(negedge clk) reset_n = 1'b1;
		rdc(A_EC, 32'h0);
		$display("test handler and resets done");
	endtask : t_svc
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// free-running 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard at 5000 cycles, far beyond the hundred or so cycles the tests need
	initial begin
		#(5000 * 100);
		err_total++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{reset_n, lrst_n, ext, vc, wat, bk, sdone, occ, act, chalt} = 10'h000;
		lrst_n = 1'b1;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		t_regs();
		t_events();
		t_svc();
		tally_and_finish();
	end
endmodule : dsr_block_tb
